// ---- rtl/cfi_pkg.sv ----
// Package for the counter configuration and host watchdog command interpreter
package cfi_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int TENTH_S_NS    = 100000000;
	localparam int TICK_CYCLES   = TENTH_S_NS / CLK_PERIOD_NS;
	// ----------------------------------------
	// Frame characters and limits
	// ----------------------------------------
	localparam logic [7:0] CH_AT   = 8'h40;
	localparam logic [7:0] CH_TIL  = 8'h7E;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_OK   = 8'h21;
	localparam logic [7:0] CH_BAD  = 8'h3F;
	localparam logic [7:0] CH_CR   = 8'h0D;
	localparam int         BUF_LEN = 16;
	localparam logic [7:0] TYPE_UP   = 8'h50;
	localparam logic [7:0] TYPE_FREQ = 8'h51;
	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_TYPE_LO = 8'h04;
	localparam logic [7:0] REG_TYPE_HI = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0C;
	localparam logic [7:0] REG_WDT     = 8'h10;
	localparam logic [7:0] REG_PRESET  = 8'h20;
	localparam int         CTRL_CKS_BIT = 8;
	localparam int         WST_EN_BIT   = 7;
	localparam int         WST_TO_BIT   = 2;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
	localparam logic [7:0]  FT_RST      = 8'h0A;
	localparam logic [31:0] TYPE_RST    = 32'h5050_5050;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} cfi_avs_req_t;
	typedef struct packed {
		logic       valid;
		logic       err;
		logic [7:0] data;
	} cfi_rx_byte_t;
	typedef enum logic [1:0] {ST_RX = 2'b00, ST_EXEC = 2'b01, ST_SEND = 2'b10} cfi_state_t;
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0, CMD_FT_RD = 4'h1, CMD_FT_WR = 4'h2, CMD_PR_RD = 4'h3,
		CMD_PR_WR = 4'h4, CMD_SC_RD = 4'h5, CMD_SC_WR = 4'h6, CMD_ALIVE = 4'h7,
		CMD_WS_RD = 4'h8, CMD_WS_CLR = 4'h9, CMD_WS_SET = 4'hA
	} cfi_cmd_t;
endpackage

// ---- rtl/cfi_top.sv ----
// Command interpreter for counter configuration and host watchdog
`timescale 1ns/10ps
// Behaviour
// - Timeout-set command stores two-hex-digit value, tenths of a second, as frequency timeout.
// - Frequency channel with no pulse for whole timeout reports zero hertz.
// - Frequency timeout only acts on channels typed 51.
// - Timeout-set reply is valid marker plus own address only.
// - Replies start with ! when accepted, ? when rejected, then address.
// - Address field is two hex digits, 00 to FF.
// - Preset read of channel 0..7 answers eight hex digits after address.
// - Preset write stores eight-hex-digit value for selected channel.
// - Preset values only meaningful for up-counter channels, type 50.
// - Overflow-stop read returns bitmap, bit 0 is channel 0.
// - Overflow-stop write sets or clears each channel's stop-on-overflow.
// - Stop-on-overflow only affects up-counter channels, type 50.
// - Host-alive broadcast has no address and is never answered.
// - Watchdog status byte: bit 7 enabled, bit 2 timeout occurred.
// - Watchdog status is nonvolatile; timeout flag cleared only by status-clear command.
// - No reply on bad syntax, communication error or foreign address.
// - Watchdog timeout disables the watchdog until set up again.
// - Watchdog setup carries enable digit and two-hex-digit timeout.
// - Status-clear resets timeout flag; later reads show no timeout.
module cfi_top import cfi_pkg::*; #(
	parameter int TICK = TICK_CYCLES
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire cfi_avs_req_t avs_req_i,
	output logic [31:0]       avs_readdata_o,
	output logic              avs_waitrequest_o,
	input  wire cfi_rx_byte_t rx_i,
	output logic              tx_valid_o,
	input  wire logic         tx_ready_i,
	output logic [7:0]        tx_data_o,
	input  wire logic [7:0]   freq_pin_i,
	input  wire logic [7:0]   nv_wdt_status_i,
	output logic [7:0]        wdt_status_o,
	output logic [7:0]        freq_zero_o,
	output logic [7:0]        stop_ovf_o
);
	// ----------------------------------------
	// Hex helpers
	// ----------------------------------------
	function automatic logic [4:0] hexval(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			return {1'b0, 4'(c - 8'h30)};
		else if (c >= 8'h41 && c <= 8'h46)
			return {1'b0, 4'(c - 8'h37)};
		else
			return 5'h10;
	endfunction
	function automatic logic [7:0] tohex(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	cfi_state_t  state;
	logic [7:0]  buf_mem [BUF_LEN];
	logic [4:0]  rx_len;
	logic        rx_bad;
	logic [31:0] ctrl;
	logic [63:0] types;
	logic [7:0]  freq_to;
	logic [7:0]  stop_map;
	logic [31:0] preset [8];
	logic        wdt_en;
	logic [7:0]  wdt_to;
	logic        wdt_flag;
	logic        nv_loaded;
	logic [7:0]  wdt_cnt;
	logic [31:0] tick_cnt;
	logic        tick;
	logic        rep_mark;
	logic [3:0]  rep_nibs;
	logic [31:0] rep_data;
	logic [3:0]  tx_pos;
	logic [7:0]  tx_sum;
	logic        avs_ack;
	logic [7:0]  up_mask;
	logic [7:0]  freq_mask;

	wire       cks_en  = ctrl[CTRL_CKS_BIT];
	wire [7:0] my_addr = ctrl[7:0];

	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	cfi_cmd_t    d_cmd;
	logic        d_ok;
	logic        d_rej;
	logic [7:0]  d_v8;
	logic [31:0] d_v32;
	logic [2:0]  d_ch;
	logic [4:0]  blen;
	logic [7:0]  csum;
	logic [4:0]  hx;
	logic        vbad;
	logic        pbad;
	logic [4:0]  h_ch;
	logic [4:0]  h_a1;
	logic [4:0]  h_a2;
	logic [4:0]  h_k1;
	logic [4:0]  h_k2;

	always_comb begin
		d_cmd = CMD_NONE;
		d_ok  = 1'b0;
		d_rej = 1'b0;
		csum  = 8'h00;
		pbad  = 1'b0;
		d_v32 = 32'h0;
		blen  = cks_en ? rx_len - 5'd2 : rx_len;
		h_ch  = hexval(buf_mem[4]);
		h_a1  = hexval(buf_mem[1]);
		h_a2  = hexval(buf_mem[2]);
		h_k1  = hexval(buf_mem[blen[3:0]]);
		h_k2  = hexval(buf_mem[4'(blen + 5'd1)]);
		for (int i = 0; i < BUF_LEN; i++) begin
			if (5'(i) < blen)
				csum = csum + buf_mem[i];
		end
		for (int i = 0; i < 8; i++) begin
			hx    = hexval(buf_mem[5 + i]);
			pbad  = pbad | hx[4];
			d_v32 = {d_v32[27:0], hx[3:0]};
		end
		hx   = hexval(buf_mem[5]);
		vbad = hx[4];
		d_v8 = {hx[3:0], 4'h0};
		hx   = hexval(buf_mem[6]);
		vbad = vbad | hx[4];
		d_v8 = d_v8 | {4'h0, hx[3:0]};
		d_ch = buf_mem[4][2:0];
		if (buf_mem[0] == CH_AT) begin
			if (buf_mem[3] == 8'h46 && buf_mem[4] == 8'h54)
				d_cmd = (blen == 5'd5) ? CMD_FT_RD : (blen == 5'd7 && !vbad) ? CMD_FT_WR : CMD_NONE;
			else if (buf_mem[3] == 8'h53 && buf_mem[4] == 8'h43)
				d_cmd = (blen == 5'd5) ? CMD_SC_RD : (blen == 5'd7 && !vbad) ? CMD_SC_WR : CMD_NONE;
			else if (buf_mem[3] == 8'h47 && blen == 5'd5 && !h_ch[4])
				d_cmd = CMD_PR_RD;
			else if (buf_mem[3] == 8'h50 && blen == 5'd13 && !h_ch[4] && !pbad)
				d_cmd = CMD_PR_WR;
		end else if (buf_mem[0] == CH_TIL) begin
			if (buf_mem[1] == CH_STAR && buf_mem[2] == CH_STAR && blen == 5'd3)
				d_cmd = CMD_ALIVE;
			else if (buf_mem[3] == 8'h30 && blen == 5'd4)
				d_cmd = CMD_WS_RD;
			else if (buf_mem[3] == 8'h31 && blen == 5'd4)
				d_cmd = CMD_WS_CLR;
			else if (buf_mem[3] == 8'h33 && blen == 5'd7 && !vbad)
				d_cmd = CMD_WS_SET;
		end
		if (d_cmd == CMD_ALIVE)
			d_ok = 1'b1;
		else if (d_cmd != CMD_NONE && !h_a1[4] && !h_a2[4])
			d_ok = {h_a1[3:0], h_a2[3:0]} == my_addr;
		if (cks_en && csum != {h_k1[3:0], h_k2[3:0]})
			d_ok = 1'b0;
		if (d_cmd == CMD_PR_RD || d_cmd == CMD_PR_WR)
			d_rej = buf_mem[4] > 8'h37 || !up_mask[d_ch];
		if (d_cmd == CMD_WS_SET)
			d_rej = buf_mem[4] != 8'h30 && buf_mem[4] != 8'h31;
	end

	wire exec_go  = state == ST_EXEC && d_ok;
	wire do_ft    = exec_go && d_cmd == CMD_FT_WR;
	wire do_pr    = exec_go && d_cmd == CMD_PR_WR && !d_rej;
	wire do_sc    = exec_go && d_cmd == CMD_SC_WR;
	wire do_alive = exec_go && d_cmd == CMD_ALIVE;
	wire do_clr   = exec_go && d_cmd == CMD_WS_CLR;
	wire do_set   = exec_go && d_cmd == CMD_WS_SET && !d_rej;
	wire has_rep  = exec_go && d_cmd != CMD_ALIVE;
	wire [3:0] tx_last = rep_nibs + (cks_en ? 4'd5 : 4'd3);

	// ----------------------------------------
	// Receive and command state machine
	// ----------------------------------------
	wire rx_cr = rx_i.valid && rx_i.data == CH_CR;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state  <= ST_RX;
			rx_len <= 5'd0;
			rx_bad <= 1'b0;
		end else begin
			case (state)
				ST_RX: begin
					if (rx_cr) begin
						state  <= (!rx_bad && !rx_i.err && rx_len != 5'd0) ? ST_EXEC : ST_RX;
						rx_bad <= 1'b0;
						if (rx_bad || rx_i.err)
							rx_len <= 5'd0;
					end else if (rx_i.valid) begin
						if (rx_i.err || rx_len == 5'(BUF_LEN))
							rx_bad <= 1'b1;
						else
							rx_len <= rx_len + 5'd1;
					end
				end
				ST_EXEC: begin
					rx_len <= 5'd0;
					state  <= has_rep ? ST_SEND : ST_RX;
				end
				ST_SEND: begin
					if (tx_ready_i && tx_pos == tx_last)
						state <= ST_RX;
				end
				default: state <= ST_RX;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (state == ST_RX && rx_i.valid && !rx_cr && rx_len < 5'(BUF_LEN))
			buf_mem[rx_len[3:0]] <= rx_i.data;
	end

	// ----------------------------------------
	// Reply generation
	// ----------------------------------------
	logic [7:0] next_char;
	logic [3:0] nib;
	wire  [7:0] next_sum = tx_sum + tx_data_o;
	wire  [3:0] npos     = tx_pos + 4'd1;
	always_comb begin
		nib = 4'(rep_data >> (4 * (rep_nibs - (npos - 4'd2))));
		if (npos == 4'd1)
			next_char = tohex(my_addr[7:4]);
		else if (npos == 4'd2)
			next_char = tohex(my_addr[3:0]);
		else if (npos < rep_nibs + 4'd3)
			next_char = tohex(nib);
		else if (npos == tx_last)
			next_char = CH_CR;
		else if (npos == rep_nibs + 4'd3)
			next_char = tohex(next_sum[7:4]);
		else
			next_char = tohex(tx_sum[3:0]);
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rep_mark  <= 1'b0;
			rep_nibs  <= 4'd0;
			rep_data  <= 32'h0;
			tx_pos    <= 4'd0;
			tx_sum    <= 8'h00;
			tx_data_o <= 8'h00;
		end else if (state == ST_EXEC) begin
			rep_mark  <= !d_rej;
			tx_data_o <= d_rej ? CH_BAD : CH_OK;
			tx_pos    <= 4'd0;
			tx_sum    <= 8'h00;
			rep_nibs  <= 4'd0;
			rep_data  <= 32'h0;
			if (!d_rej) begin
				case (d_cmd)
					CMD_FT_RD: begin
						rep_nibs <= 4'd2;
						rep_data <= {24'h0, freq_to};
					end
					CMD_PR_RD: begin
						rep_nibs <= 4'd8;
						rep_data <= preset[d_ch];
					end
					CMD_SC_RD: begin
						rep_nibs <= 4'd2;
						rep_data <= {24'h0, stop_map};
					end
					CMD_WS_RD: begin
						rep_nibs <= 4'd2;
						rep_data <= {24'h0, wdt_status_o};
					end
					default: rep_nibs <= 4'd0;
				endcase
			end
		end else if (state == ST_SEND && tx_ready_i) begin
			tx_pos    <= npos;
			tx_sum    <= next_sum;
			tx_data_o <= next_char;
		end
	end
	assign tx_valid_o = state == ST_SEND;

	// ----------------------------------------
	// Configuration and watchdog state
	// ----------------------------------------
	// Write lands at the edge where waitrequest is low
	wire avs_wr = avs_req_i.write && avs_ack;
	wire wdt_exp = wdt_en && wdt_to != 8'h00 && tick && wdt_cnt + 8'd1 >= wdt_to;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			freq_to   <= FT_RST;
			stop_map  <= 8'h00;
			wdt_en    <= 1'b0;
			wdt_to    <= 8'h00;
			wdt_flag  <= 1'b0;
			nv_loaded <= 1'b0;
			wdt_cnt   <= 8'h00;
			ctrl      <= CTRL_RST;
			types     <= {TYPE_RST, TYPE_RST};
		end else begin
			nv_loaded <= 1'b1;
			if (do_ft)
				freq_to <= d_v8;
			if (do_sc)
				stop_map <= d_v8;
			if (avs_wr && avs_req_i.address == REG_CTRL)
				ctrl <= avs_req_i.writedata;
			if (avs_wr && avs_req_i.address == REG_TYPE_LO)
				types[31:0] <= avs_req_i.writedata;
			if (avs_wr && avs_req_i.address == REG_TYPE_HI)
				types[63:32] <= avs_req_i.writedata;
			// Status restored once after reset, so it survives power cycles
			if (!nv_loaded) begin
				wdt_en   <= nv_wdt_status_i[WST_EN_BIT];
				wdt_flag <= nv_wdt_status_i[WST_TO_BIT];
			end else begin
				if (wdt_exp)
					wdt_flag <= 1'b1;
				else if (do_clr)
					wdt_flag <= 1'b0;
				if (wdt_exp)
					wdt_en <= 1'b0;
				else if (do_set)
					wdt_en <= buf_mem[4][0];
			end
			if (do_set)
				wdt_to <= d_v8;
			if (do_alive || do_set || !wdt_en || wdt_exp)
				wdt_cnt <= 8'h00;
			else if (tick)
				wdt_cnt <= wdt_cnt + 8'd1;
		end
	end
	assign wdt_status_o = {wdt_en, 4'h0, wdt_flag, 2'b00};

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt <= 32'h0;
			tick     <= 1'b0;
		end else begin
			tick     <= tick_cnt == 32'(TICK - 1);
			tick_cnt <= (tick_cnt == 32'(TICK - 1)) ? 32'h0 : tick_cnt + 32'h1;
		end
	end

	// ----------------------------------------
	// Per-channel preset, overflow stop and frequency timeout
	// ----------------------------------------
	for (genvar c = 0; c < 8; c++) begin : g_ch
		logic [2:0] sync;
		logic [7:0] idle;
		assign up_mask[c]   = types[8*c +: 8] == TYPE_UP;
		assign freq_mask[c] = types[8*c +: 8] == TYPE_FREQ;
		assign stop_ovf_o[c] = stop_map[c] && up_mask[c];
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				preset[c]      <= 32'h0;
				sync           <= 3'b000;
				idle           <= 8'h00;
				freq_zero_o[c] <= 1'b0;
			end else begin
				if (do_pr && d_ch == 3'(c))
					preset[c] <= d_v32;
				sync <= {sync[1:0], freq_pin_i[c]};
				// A pulse counts when the second stage is high and the third stage is still low
				if (sync[1] && !sync[2])
					idle <= 8'h00;
				else if (tick && idle != 8'hFF)
					idle <= idle + 8'd1;
				freq_zero_o[c] <= freq_mask[c] && idle >= freq_to;
			end
		end
	end

	// ----------------------------------------
	// Avalon-MM slave, one wait cycle per access
	// ----------------------------------------
	wire [31:0] rd_mux =
		avs_req_i.address == REG_CTRL    ? ctrl :
		avs_req_i.address == REG_TYPE_LO ? types[31:0] :
		avs_req_i.address == REG_TYPE_HI ? types[63:32] :
		avs_req_i.address == REG_STATUS  ? {freq_zero_o, stop_map, freq_to, wdt_status_o} :
		avs_req_i.address == REG_WDT     ? {23'h0, wdt_en, wdt_to} :
		avs_req_i.address[7:5] == REG_PRESET[7:5] && avs_req_i.address[4:2] <= 3'd7 ?
			preset[avs_req_i.address[4:2]] : 32'h0;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_ack        <= 1'b0;
			avs_readdata_o <= 32'h0;
		end else begin
			avs_ack <= (avs_req_i.read || avs_req_i.write) && !avs_ack;
			if (avs_req_i.read && !avs_ack)
				avs_readdata_o <= rd_mux;
		end
	end
	assign avs_waitrequest_o = (avs_req_i.read || avs_req_i.write) && !avs_ack;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	alive_silent_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_alive |=> state == ST_RX) else $error("reply to host-alive");
	foreign_silent_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state == ST_EXEC && !d_ok |=> state == ST_RX) else $error("reply without match");
	reply_marker_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(tx_valid_o) |-> tx_data_o == CH_OK || tx_data_o == CH_BAD) else $error("bad marker");
	wdt_expire_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wdt_exp |=> wdt_flag && !wdt_en) else $error("expiry not taken");
	wdt_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_clr && !wdt_exp |=> !wdt_flag) else $error("clear ignored");
	ft_store_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		do_ft |=> freq_to == $past(d_v8)) else $error("timeout not stored");
	sc_map_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		stop_ovf_o == (stop_map & up_mask)) else $error("stop map leak");
	preset_rej_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		exec_go && d_cmd == CMD_PR_RD && !up_mask[d_ch] |=> tx_data_o == CH_BAD) else $error("no reject");
	avs_wait_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait too long");
	frame_end_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		state == ST_SEND && tx_ready_i && tx_pos == tx_last |-> tx_data_o == CH_CR) else $error("no CR");
	cv_preset_rd_c: cover property (@(posedge sys_clk_i) exec_go && d_cmd == CMD_PR_RD);
	cv_alive_c: cover property (@(posedge sys_clk_i) do_alive);
	cv_expire_c: cover property (@(posedge sys_clk_i) wdt_exp);
endmodule

// ---- bench/cfi_host_model.sv ----
// Host computer model for the serial command link
`timescale 1ns/10ps
module cfi_host_model import cfi_pkg::*; (
	input  wire logic       sys_clk_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output cfi_rx_byte_t    rx_o,
	output logic            tx_ready_o
);
	initial begin
		rx_o = '0;
		tx_ready_o = 1'b0;
	end
	// ------
	// Frame check characters
	// ------
	function automatic string cks_str(input string s);
		logic [7:0] sum;
		sum = 8'h00;
		for (int i = 0; i < s.len(); i++) sum += s[i];
		return $sformatf("%02X", sum);
	endfunction
	// ------
	// One command frame and its reply
	// ------
	// Idle data shows the inverse of the last char so no stale value looks valid
	task automatic xfer(input string cmd, input bit cks, input int err_at, input bit slow,
		output string rsp, output bit hung);
		string s;
		bit    done;
		byte   c;
		s = cks ? {cmd, cks_str(cmd)} : cmd;
		s = {s, "\r"};
		rsp = "";
		done = 1'b0;
		for (int i = 0; i < s.len(); i++) begin
			c = s[i];
			@(posedge sys_clk_i);
			rx_o <= '{valid: 1'b1, err: (i == err_at), data: c};
			@(posedge sys_clk_i);
			rx_o <= '{valid: 1'b0, err: 1'b0, data: ~c};
		end
		// Slow mode stalls every other cycle
		for (int n = 0; n < 60 && !done; n++) begin
			@(posedge sys_clk_i);
			if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
				c = tx_data_i;
				if (tx_data_i === CH_CR) done = 1'b1;
				else rsp = {rsp, string'(c)};
			end
			tx_ready_o <= done ? 1'b0 : (slow ? n[0] : 1'b1);
		end
		if (!done) begin
			@(posedge sys_clk_i);
			tx_ready_o <= 1'b0;
		end
		hung = !done && rsp.len() > 0;
	endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking testbench for the command interpreter
`timescale 1ns/10ps
module testbench import cfi_pkg::*;;
	typedef struct {
		string cmd;
		string rsp;
	} cfi_row_t;
	logic         sys_clk_i;
	logic         rst_i;
	cfi_avs_req_t avs_req_i;
	logic [31:0]  avs_readdata_o;
	logic         avs_waitrequest_o;
	cfi_rx_byte_t rx_i;
	logic         tx_valid_o;
	logic         tx_ready_i;
	logic [7:0]   tx_data_o;
	logic [7:0]   freq_pin_i;
	logic [7:0]   nv_wdt_status_i;
	logic [7:0]   wdt_status_o;
	logic [7:0]   freq_zero_o;
	logic [7:0]   stop_ovf_o;
	int           miscompares;
	int           checks_done;
	cfi_row_t rows [23] = '{
		'{"@01FT", "!010A"}, '{"~010", "!0104"}, '{"@01FT05", "!01"},
		'{"~010", "!0104"}, '{"~011", "!01"}, '{"~010", "!0100"},
		'{"@01FT", "!0105"}, '{"@01FTFF", "!01"}, '{"@01FT", "!01FF"},
		'{"@01FT05", "!01"}, '{"@01P2F0000000", "!01"}, '{"@01G2", "!01F0000000"},
		'{"@01P712345678", "!01"}, '{"@01G7", "!0112345678"}, '{"@01G8", "?01"},
		'{"@01SC3A", "!01"}, '{"@01SC", "!013A"}, '{"~**", ""},
		'{"~020", ""}, '{"@01XY", ""}, '{"~013200", "?01"},
		'{"~013005", "!01"}, '{"~010", "!0100"}
	};
	cfi_top #(.TICK(20)) i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_req_i(avs_req_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rx_i(rx_i),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
		.freq_pin_i(freq_pin_i), .nv_wdt_status_i(nv_wdt_status_i), .wdt_status_o(wdt_status_o),
		.freq_zero_o(freq_zero_o), .stop_ovf_o(stop_ovf_o));
	cfi_host_model i_host (.sys_clk_i(sys_clk_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
		.rx_o(rx_i), .tx_ready_o(tx_ready_i));
	always #2.5 sys_clk_i = ~sys_clk_i;
	// ------
	// Checks and bus cycles
	// ------
	task automatic print_verdict();
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk_s(input string what, input string exp, input string got);
		checks_done++;
		if (exp != got) begin
			miscompares++;
			$display("[FAIL] %s expected '%s' seen '%s'", what, exp, got);
		end
	endtask
	task automatic chk_v(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Held until waitrequest is seen low; data taken at that edge
	task automatic avs(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		bit ok;
		ok = 1'b0;
		@(posedge sys_clk_i);
		avs_req_i <= '{read: !wr, write: wr, address: a, writedata: wd};
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge sys_clk_i);
			ok = (avs_waitrequest_o === 1'b0);
		end
		rd = avs_readdata_o;
		avs_req_i <= '0;
		if (!ok) begin
			chk_s("bus wait", "answer", "timeout");
			print_verdict();
		end
	endtask
	task automatic frame(input string c, input string exp, input bit cks = 0, input int err_at = -1,
		input bit slow = 0);
		string r;
		string e;
		bit    hung;
		i_host.xfer(c, cks, err_at, slow, r, hung);
		e = (cks && exp.len() > 0) ? {exp, i_host.cks_str(exp)} : exp;
		chk_s(c, e, r);
		if (hung) begin
			chk_s("reply end", "CR", "timeout");
			print_verdict();
		end
	endtask
	// ------
	// Main sequence
	// ------
	initial begin
		logic [31:0] rd;
		sys_clk_i = 1'b0;
		rst_i = 1'b1;
		avs_req_i = '0;
		freq_pin_i = 8'h00;
		nv_wdt_status_i = 8'h04;
		miscompares = 0;
		checks_done = 0;
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk_v("nv status", 32'h0000_0004, {24'h0, wdt_status_o});
		avs(1'b0, REG_CTRL, 32'h0, rd);
		chk_v("ctrl reset", CTRL_RST, rd);
		avs(1'b0, REG_TYPE_LO, 32'h0, rd);
		chk_v("type reset", TYPE_RST, rd);
		avs(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
		avs(1'b0, 8'h40, 32'h0, rd);
		chk_v("unmapped", 32'h0, rd);
		foreach (rows[i]) frame(rows[i].cmd, rows[i].rsp, 1'b0, -1, i[0]);
		chk_v("stop map", 32'h0000_003A, {24'h0, stop_ovf_o});
		avs(1'b0, REG_STATUS, 32'h0, rd);
		chk_v("status low", 32'h0000_0500, rd & 32'h0000_FFFF);
		// Channels 0 and 1 become frequency channels
		avs(1'b1, REG_TYPE_LO, 32'h5050_5151, rd);
		frame("@01G1", "?01");
		frame("@01G2", "!01F0000000");
		chk_v("stop masked", 32'h0000_0038, {24'h0, stop_ovf_o});
		repeat (130) @(posedge sys_clk_i);
		chk_v("freq zero", 32'h0000_0003, {24'h0, freq_zero_o});
		freq_pin_i <= 8'h01;
		repeat (10) @(posedge sys_clk_i);
		chk_v("freq pulse", 32'h0000_0002, {24'h0, freq_zero_o});
		repeat (130) @(posedge sys_clk_i);
		chk_v("freq idle", 32'h0000_0003, {24'h0, freq_zero_o});
		// Address FF with frame check characters
		avs(1'b1, REG_CTRL, 32'h0000_01FF, rd);
		frame("@FFFT", "!FF05", 1'b1);
		frame("@FFFT", "");
		frame("@01FT", "", 1'b1);
		avs(1'b1, REG_CTRL, 32'h0000_0001, rd);
		frame("@01FT", "", 1'b0, 2);
		// Watchdog armed for five tenths, kept alive, then left to expire
		frame("~013105", "!01");
		frame("~010", "!0180");
		repeat (3) frame("~**", "");
		frame("~010", "!0180", 1'b0, -1, 1'b1);
		repeat (140) @(posedge sys_clk_i);
		chk_v("wdt out", 32'h0000_0004, {24'h0, wdt_status_o});
		frame("~010", "!0104");
		// Second reset restores the stored status image
		rst_i <= 1'b1;
		nv_wdt_status_i <= 8'h84;
		repeat (2) @(posedge sys_clk_i);
		chk_v("wdt in reset", 32'h0, {24'h0, wdt_status_o});
		rst_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		chk_v("nv reload", 32'h0000_0084, {24'h0, wdt_status_o});
		frame("~010", "!0184");
		frame("@01FT", "!010A");
		print_verdict();
	end
endmodule
